// [pvic_consts.svh]
`ifndef PVIC_CONSTS_SVH
`define PVIC_CONSTS_SVH
`define PVIC_NUM_LEVELS 8
`define PVIC_VEC_L0 12'h040
`define PVIC_VEC_L1 12'h080
`define PVIC_VEC_L2 12'h0C0
`define PVIC_VEC_L3 12'h100
`define PVIC_VEC_L4 12'h140
`define PVIC_VEC_L5 12'h180
`define PVIC_VEC_L6 12'h1C0
`define PVIC_VEC_L7 12'h1E0
`define PVIC_RESET_VEC 12'h008
`define PVIC_RESET_OPCODE 8'hC1
`define PVIC_PEND_RST 8'h00
`define PVIC_ACT_RST 8'h00
`define PVIC_CLK_PER_MC 2
`define PVIC_LAT_MIN_MC 3
`define PVIC_LAT_MAX_MC 5
`define PVIC_IO_ADDRS 16
`endif

// [pvic_pkg.sv]
`default_nettype none
package pvic_pkg;
  typedef logic [7:0] pvic_lvl_t;
  typedef struct packed {
    logic [3:0] hi_nib;
    logic [3:0] lo_nib;
  } pvic_swi_t;
  typedef struct packed {
    logic timer1;
    logic serial_buf;
    logic port4_pin0;
    logic port4_pin3;
    logic timer2;
    logic volt_mon;
  } pvic_src_t;
  typedef struct packed {
    logic timer1_mask;
    logic serial_mask;
    logic timer2_mask;
    logic volt_mon_mask;
  } pvic_mask_t;
  typedef enum logic [1:0] {
    PVIC_ST_RESET = 2'b00,
    PVIC_ST_BOOT = 2'b01,
    PVIC_ST_RUN = 2'b10
  } pvic_state_t;
endpackage : pvic_pkg
`default_nettype wire

// [pvic_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none
// any-edge detector for one port pin, enabled by two control bits
module pvic_edge_det (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic pin, // port pin level
  input wire logic [1:0] mode, // port control bits, 00 = off
  output logic edge_pulse // one-cycle edge pulse
);
  logic pin_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_r <= pin; // track the pin so release gives no false edge
    end else begin
      pin_r <= pin;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= (mode != 2'h0) && (pin ^ pin_r);
    end
  end
endmodule : pvic_edge_det
`default_nettype wire

// [pvic_prio_enc.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pvic_consts.svh"
// fixed priority: level 7 highest, level 0 lowest
module pvic_prio_enc
  import pvic_pkg::*;
(
  input wire pvic_lvl_t req, // request vector
  output logic any, // any bit set
  output logic [2:0] idx // highest set bit
);
  always_comb begin
    any = 1'b0;
    idx = 3'h0;
    for (int i = 0; i < `PVIC_NUM_LEVELS; i++) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule : pvic_prio_enc
`default_nettype wire

// [pvic_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pvic_consts.svh"
// Overview of operation
// - eight levels, fixed priority, seven highest
// - each level has its own vector
// - pending and active registers, eight bits
// - sample requests every non-I/O cycle
// - request only when no higher active
// - acknowledge: short call, push PC
// - return clears level pending and active
// - disabled: log requests, start none
// - request on set pending bit absorbed
// - latency three to five machine cycles; not enforced, call follows one clock after ack_take
// - machine cycle is two clocks
// - soft interrupt writes two nibbles pending
// - ten sources, six levels, maskable
// - port5 pin edges drive levels one, six
// - timers, serial, port4, voltage monitor mapping
// - master reset unmaskable, many triggers
// - reset clears enable, pending, active
// - reset: I/O bus reset, ports input
// - release: short call C1h to 008h
// - I/O instructions reach sixteen addresses
// - enable cleared by reset or disable
module pvic_ctrl
  import pvic_pkg::*;
#(
  parameter int CLK_PER_MC = `PVIC_CLK_PER_MC // clocks per machine cycle
) (
  input wire logic clk, // system clock, 40 MHz
  input wire logic srst, // master reset, sync, active high
  input wire logic por_active, // power-on reset phase
  input wire logic io_cycle, // current instruction is an I/O cycle
  input wire logic [3:0] io_addr, // primary I/O address
  input wire logic io_wr, // I/O write strobe
  input wire logic [3:0] io_wdata, // I/O write data
  input wire logic soft_irq_instr, // software interrupt executes
  input wire pvic_swi_t swi_data, // two stack_top nibbles
  input wire logic enable_irq_instr, // enable instruction
  input wire logic disable_irq_instr, // disable instruction
  input wire logic sleep_instr, // sleep instruction
  input wire logic return_from_service, // return instruction
  input wire logic ack_take, // CPU takes acknowledge cycle
  input wire logic [11:0] pc_in, // current program counter
  input wire logic port5_pin0, // port 5 pin 0
  input wire logic port5_pin1, // port 5 pin 1
  input wire logic port5_pin2, // port 5 pin 2
  input wire logic port5_pin3, // port 5 pin 3
  input wire logic [7:0] port5_ctrl, // two bits per port5 pin
  input wire pvic_src_t src, // peripheral event pulses
  input wire pvic_mask_t masks, // source masks, 1 = disabled
  output logic irq_req, // interrupt signal to CPU
  output logic irq_en, // global enable flag
  output pvic_lvl_t pend_r, // pending register
  output pvic_lvl_t act_r, // active register
  output logic call_valid, // short call issued, one cycle
  output logic [7:0] call_opcode, // short call opcode
  output logic [11:0] call_addr, // short call target
  output logic push_valid, // push PC onto return stack
  output logic [11:0] push_pc, // PC to push
  output logic pop_valid, // reload PC from return stack
  output logic io_bus_reset, // I/O bus in reset mode
  output logic ports_input, // force bidirectional ports input
  output logic [15:0] io_sel // one-hot I/O address decode
);
  // ************************************************************
  // machine cycle phase
  // ************************************************************
  logic [1:0] phase_r;
  logic mc_end;
  pvic_state_t state_r;
  logic [3:0] lat_cnt_r;

  assign mc_end = (phase_r == 2'(CLK_PER_MC - 1));

  always_ff @(posedge clk) begin
    if (srst || phase_r == 2'(CLK_PER_MC - 1)) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // ************************************************************
  // level vectors
  // ************************************************************
  function automatic logic [11:0] lvl_vec(input logic [2:0] l);
    case (l)
      3'h0: lvl_vec = `PVIC_VEC_L0;
      3'h1: lvl_vec = `PVIC_VEC_L1;
      3'h2: lvl_vec = `PVIC_VEC_L2;
      3'h3: lvl_vec = `PVIC_VEC_L3;
      3'h4: lvl_vec = `PVIC_VEC_L4;
      3'h5: lvl_vec = `PVIC_VEC_L5;
      3'h6: lvl_vec = `PVIC_VEC_L6;
      default: lvl_vec = `PVIC_VEC_L7;
    endcase
  endfunction : lvl_vec

  // short call opcode from vector bits 8..3
  function automatic logic [7:0] lvl_op(input logic [11:0] v);
    lvl_op = {2'b11, v[8:3]};
  endfunction : lvl_op

  // ************************************************************
  // hardware sources
  // ************************************************************
  logic [3:0] p5_edge;
  logic [3:0] p5_pins;
  assign p5_pins = {port5_pin3, port5_pin2, port5_pin1, port5_pin0};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_p5
      pvic_edge_det u_edge (
        .clk(clk),
        .srst(srst),
        .pin(p5_pins[g]),
        .mode(port5_ctrl[2*g+1:2*g]),
        .edge_pulse(p5_edge[g])
      );
    end
  endgenerate

  pvic_lvl_t hw_req;
  always_comb begin
    hw_req = 8'h00;
    hw_req[1] = p5_edge[2] | p5_edge[3];
    hw_req[6] = p5_edge[0] | p5_edge[1];
    hw_req[2] = src.timer1 & ~masks.timer1_mask;
    hw_req[3] = (src.serial_buf | src.port4_pin0 | src.port4_pin3)
                & ~masks.serial_mask;
    hw_req[4] = src.timer2 & ~masks.timer2_mask;
    hw_req[7] = src.volt_mon & ~masks.volt_mon_mask;
  end

  // requests held until the next non-I/O sample point
  pvic_lvl_t req_hold_r;
  logic sample;
  assign sample = mc_end && !io_cycle;

  always_ff @(posedge clk) begin
    if (srst || sample) begin
      req_hold_r <= 8'h00;
    end else begin
      req_hold_r <= req_hold_r | hw_req;
    end
  end

  // ************************************************************
  // priority selection
  // ************************************************************
  logic act_any;
  logic [2:0] act_top;
  logic cand_any;
  logic [2:0] cand_top;
  pvic_lvl_t cand;

  pvic_prio_enc u_act (.req(act_r), .any(act_any), .idx(act_top));

  always_comb begin
    cand = pend_r & ~act_r;
    for (int i = 0; i < `PVIC_NUM_LEVELS; i++) begin
      if (act_any && 3'(i) <= act_top) begin
        cand[i] = 1'b0;
      end
    end
  end

  pvic_prio_enc u_cand (.req(cand), .any(cand_any), .idx(cand_top));

  assign irq_req = cand_any;

  // ************************************************************
  // pending and active registers
  // ************************************************************
  logic ack_fire;
  logic ret_any;
  logic [2:0] ret_lvl;
  pvic_lvl_t ret_mask;
  pvic_lvl_t swi_bits;

  assign ack_fire = ack_take && cand_any && irq_en && state_r == PVIC_ST_RUN;
  pvic_prio_enc u_ret (.req(act_r), .any(ret_any), .idx(ret_lvl));
  assign ret_mask = (return_from_service && ret_any) ? pvic_lvl_t'(8'h01 << ret_lvl) : 8'h00;
  assign swi_bits = soft_irq_instr ? pvic_lvl_t'(swi_data) : 8'h00;

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_r <= `PVIC_PEND_RST;
    end else begin
      // set wins over clear; a set bit absorbs a repeat
      pend_r <= (pend_r & ~ret_mask) | (sample ? (req_hold_r | hw_req) : 8'h00)
                | swi_bits;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      act_r <= `PVIC_ACT_RST;
    end else if (ack_fire) begin
      act_r <= (act_r & ~ret_mask) | pvic_lvl_t'(8'h01 << cand_top);
    end else begin
      act_r <= act_r & ~ret_mask;
    end
  end

  // ************************************************************
  // global enable flag
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_en <= 1'b0;
    end else if (disable_irq_instr) begin
      irq_en <= 1'b0;
    end else if (enable_irq_instr || sleep_instr) begin
      irq_en <= 1'b1;
    end
  end

  // ************************************************************
  // reset sequencing and CPU call outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= PVIC_ST_RESET;
    end else begin
      case (state_r)
        PVIC_ST_RESET: state_r <= PVIC_ST_BOOT;
        PVIC_ST_BOOT: state_r <= PVIC_ST_RUN;
        default: state_r <= PVIC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      call_valid <= 1'b0;
      call_opcode <= 8'h00;
      call_addr <= 12'h000;
      push_valid <= 1'b0;
      push_pc <= 12'h000;
      pop_valid <= 1'b0;
    end else begin
      call_valid <= 1'b0;
      push_valid <= 1'b0;
      pop_valid <= return_from_service;
      if (state_r == PVIC_ST_BOOT) begin
        call_valid <= 1'b1;
        call_opcode <= `PVIC_RESET_OPCODE;
        call_addr <= `PVIC_RESET_VEC;
      end else if (ack_fire) begin
        call_valid <= 1'b1;
        call_addr <= lvl_vec(cand_top);
        call_opcode <= lvl_op(lvl_vec(cand_top));
        push_valid <= 1'b1;
        push_pc <= pc_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      io_bus_reset <= 1'b1;
      ports_input <= 1'b1;
    end else begin
      io_bus_reset <= por_active;
      ports_input <= por_active;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      io_sel <= 16'h0000;
    end else begin
      io_sel <= (io_cycle && io_wr) ? 16'(16'h0001 << io_addr) : 16'h0000;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [7:0] lat_cnt_unused;
  assign lat_cnt_unused = {lat_cnt_r, io_wdata};
  always_ff @(posedge clk) begin
    if (srst || ack_fire || !irq_req) begin
      lat_cnt_r <= 4'h0;
    end else if (lat_cnt_r != 4'hF) begin
      lat_cnt_r <= lat_cnt_r + 4'h1;
    end
  end

  AST_RESET_CLEARS: assert property (@(posedge clk)
    srst |=> (pend_r == 8'h00 && act_r == 8'h00 && !irq_en))
    else $error("reset did not clear interrupt state");
  AST_NO_START_DISABLED: assert property (@(posedge clk) disable iff (srst)
    !irq_en |=> !push_valid)
    else $error("service started while disabled");
  AST_REQ_ABOVE_ACTIVE: assert property (@(posedge clk) disable iff (srst)
    irq_req |-> (pend_r & ~act_r) != 8'h00 && (act_r == 8'h00 || cand_top > act_top))
    else $error("request not above active level");
  AST_ACK_VECTOR: assert property (@(posedge clk) disable iff (srst)
    ack_fire |=> push_valid && call_addr == lvl_vec($past(cand_top)) && act_r[$past(cand_top)])
    else $error("acknowledge vector or active bit wrong");
  AST_RETURN_CLEARS: assert property (@(posedge clk) disable iff (srst)
    (return_from_service && ret_any && !ack_fire && !soft_irq_instr && !sample)
      |=> !act_r[$past(ret_lvl)] && !pend_r[$past(ret_lvl)] && pop_valid)
    else $error("return did not clear level");
  AST_BOOT_CALL: assert property (@(posedge clk) disable iff (srst)
    $past(srst) ##1 1'b1 |=> call_valid && call_addr == `PVIC_RESET_VEC
      && call_opcode == `PVIC_RESET_OPCODE)
    else $error("reset call missing");
  AST_SWI_LOGS: assert property (@(posedge clk) disable iff (srst)
    soft_irq_instr |=> (pend_r & $past(swi_data)) == $past(swi_data))
    else $error("software interrupt not logged");
  AST_PEND_STICKY: assert property (@(posedge clk) disable iff (srst)
    (pend_r[0] && !return_from_service) |=> pend_r[0])
    else $error("pending bit lost");
  AST_DI_CLEARS: assert property (@(posedge clk) disable iff (srst)
    disable_irq_instr |=> !irq_en)
    else $error("disable did not clear enable");
  AST_MC_TWO: assert property (@(posedge clk) disable iff (srst)
    mc_end |=> !mc_end ##1 mc_end)
    else $error("machine cycle not two clocks");
endmodule : pvic_ctrl
`default_nettype wire

// [pvic_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ************************
// core sequencer stand-in
// ************************
module pvic_cpu_model (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic irq_req, // interrupt signal
  input wire logic call_valid, // short call issued
  input wire logic [11:0] call_addr, // short call target
  input wire logic [1:0] stall, // extra wait cycles
  output logic ack_take, // ready to acknowledge
  output logic return_from_service, // return pulse
  output logic [11:0] pc_in // program counter
);
  logic busy_r;
  logic [3:0] cnt_r;
  // acknowledge only when idle, after stall cycles of request
  assign ack_take = !busy_r && irq_req && (cnt_r >= {2'b00, stall});
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      return_from_service <= 1'b0;
      pc_in <= 12'h200;
    end else begin
      return_from_service <= 1'b0;
      if (return_from_service) begin
        busy_r <= 1'b0;
        cnt_r <= 4'h0;
        pc_in <= pc_in + 12'h001;
      end else if (call_valid && call_addr != 12'h008) begin
        busy_r <= 1'b1;
        cnt_r <= 4'h0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == {2'b00, stall} + 4'h2) begin
          return_from_service <= 1'b1;
        end
      end else begin
        cnt_r <= irq_req ? cnt_r + {3'b000, cnt_r != 4'hF} : 4'h0;
      end
    end
  end
endmodule : pvic_cpu_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pvic_consts.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
  import pvic_pkg::*;
  logic clk = 1'b0, srst = 1'b1, por_active = 1'b1, io_cycle = 1'b0, io_wr = 1'b0;
  logic soft_irq = 1'b0, en_i = 1'b0, dis_i = 1'b0, slp_i = 1'b0;
  logic [3:0] io_addr = 4'h0, p5 = 4'h0;
  logic [7:0] p5_ctrl = 8'h00, pat;
  logic [1:0] stall = 2'h0;
  pvic_swi_t swi_data = '0;
  pvic_src_t src = '0;
  pvic_mask_t masks = '0;
  logic ack_take, ret, irq_req, irq_en, call_valid, push_valid, pop_valid;
  logic io_bus_reset, ports_input;
  logic [11:0] pc_in, call_addr, push_pc;
  logic [7:0] call_opcode;
  pvic_lvl_t pend_r, act_r;
  logic [15:0] io_sel;
  logic [22:0] exp_q[$];
  logic [22:0] e;
  logic [11:0] vec_tbl [8] = '{`PVIC_VEC_L0, `PVIC_VEC_L1, `PVIC_VEC_L2, `PVIC_VEC_L3,
    `PVIC_VEC_L4, `PVIC_VEC_L5, `PVIC_VEC_L6, `PVIC_VEC_L7};
  int lvl_tbl [6] = '{2, 3, 3, 3, 4, 7};
  int failures = 0, checked = 0, pops = 0, pops0, n, k;
  integer seed = 32'hcd77c49d;
  pvic_ctrl pvic_ctrl_inst (.clk(clk), .srst(srst), .por_active(por_active),
    .io_cycle(io_cycle), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(4'h0),
    .soft_irq_instr(soft_irq), .swi_data(swi_data), .enable_irq_instr(en_i),
    .disable_irq_instr(dis_i), .sleep_instr(slp_i), .return_from_service(ret),
    .ack_take(ack_take), .pc_in(pc_in), .port5_pin0(p5[0]), .port5_pin1(p5[1]),
    .port5_pin2(p5[2]), .port5_pin3(p5[3]), .port5_ctrl(p5_ctrl), .src(src),
    .masks(masks), .irq_req(irq_req), .irq_en(irq_en), .pend_r(pend_r), .act_r(act_r),
    .call_valid(call_valid), .call_opcode(call_opcode), .call_addr(call_addr),
    .push_valid(push_valid), .push_pc(push_pc), .pop_valid(pop_valid),
    .io_bus_reset(io_bus_reset), .ports_input(ports_input), .io_sel(io_sel));
  pvic_cpu_model pvic_cpu_model_inst (.clk(clk), .srst(srst), .irq_req(irq_req),
    .call_valid(call_valid), .call_addr(call_addr), .stall(stall), .ack_take(ack_take),
    .return_from_service(ret), .pc_in(pc_in));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ****************
  // helpers
  // ****************
  task automatic tick(input int c = 1);
    repeat (c) @(posedge clk);
  endtask : tick
  task automatic stop_test;
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic expect_lvl(input int l);
    exp_q.push_back({3'(l), 2'b11, vec_tbl[l][8:3], vec_tbl[l]});
  endtask : expect_lvl
  task automatic wait_idle;
    int w;
    w = 0;
    while ((exp_q.size() != 0 || act_r !== 8'h00) && w < 300) begin
      tick();
      w++;
    end
    if (w >= 300) begin
      failures++;
      $display("ERROR %0t: wait for idle timed out", $time);
      stop_test();
    end
  endtask : wait_idle
  task automatic instr(input int w);
    case (w)
      0: en_i <= 1'b1;
      1: dis_i <= 1'b1;
      default: slp_i <= 1'b1;
    endcase
    tick();
    en_i <= 1'b0;
    dis_i <= 1'b0;
    slp_i <= 1'b0;
  endtask : instr
  task automatic do_reset;
    srst <= 1'b1;
    por_active <= 1'b1;
    tick(2);
    `CHK({pend_r, act_r, irq_en, io_bus_reset, ports_input}, {17'h0, 2'b11})
    exp_q.delete();
    exp_q.push_back({3'd0, `PVIC_RESET_OPCODE, `PVIC_RESET_VEC});
    srst <= 1'b0;
    por_active <= 1'b0;
    wait_idle();
    `CHK({io_bus_reset, ports_input}, 2'b00)
  endtask : do_reset
  // ****************
  // result watcher
  // ****************
  always @(posedge clk) begin
    if (!srst && pop_valid === 1'b1) begin
      pops++;
    end
    if (!srst && call_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("ERROR %0t: unexpected call", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK({call_opcode, call_addr}, e[19:0])
        if (e[11:0] != `PVIC_RESET_VEC) begin
          `CHK({push_valid, push_pc}, {1'b1, pc_in})
          `CHK({irq_req, act_r[e[22:20]]}, 2'b01)
        end
      end
    end
  end
  // ****************
  // sequence
  // ****************
  initial begin
    do_reset();
    for (int a = 0; a < 16; a++) begin
      io_cycle <= 1'b1;
      io_wr <= 1'b1;
      io_addr <= 4'(a);
      k = 0;
      do begin
        tick();
        k++;
      end while (io_sel === 16'h0000 && k < 4);
      `CHK(io_sel, 16'h0001 << a)
      io_wr <= 1'b0;
      io_cycle <= 1'b0;
      tick();
    end
    for (int i = 0; i < 4; i++) begin
      pat = 8'($random(seed));
      if (pat == 8'h00) pat = 8'h81;
      stall <= 2'($random(seed));
      soft_irq <= 1'b1;
      swi_data <= pat;
      tick();
      soft_irq <= 1'b0;
      tick(4);
      `CHK(pend_r, pat)
      n = 0;
      for (int l = 7; l >= 0; l--) if (pat[l]) begin
        expect_lvl(l);
        n++;
      end
      pops0 = pops;
      instr(i[0] ? 2 : 0);
      wait_idle();
      tick(2);
      `CHK({pend_r, pops - pops0}, {8'h00, n})
      instr(1);
      tick(2);
      `CHK(irq_en, 1'b0)
    end
    instr(0);
    stall <= 2'b00;
    for (int i = 0; i < 6; i++) begin
      expect_lvl(lvl_tbl[i]);
      src <= pvic_src_t'(6'b100000 >> i);
      k = 0;
      while (exp_q.size() != 0 && k < 20) begin
        tick();
        k++;
        if (k == 2) src <= '0;
      end
      if (k != 2) src <= '0;
      `CHK(k <= 11, 1'b1)
      wait_idle();
    end
    p5_ctrl <= 8'h11;
    for (int i = 0; i < 8; i++) begin
      if (i % 2 == 0) expect_lvl(i % 4 == 0 ? 6 : 1);
      p5[i % 4] <= ~p5[i % 4];
      tick(14);
      wait_idle();
      `CHK(pend_r, 8'h00)
    end
    masks <= '1;
    src <= pvic_src_t'(6'b110011);
    tick(2);
    src <= '0;
    tick(8);
    `CHK(pend_r, 8'h00)
    masks <= '0;
    instr(1);
    for (int i = 0; i < 2; i++) begin
      src <= pvic_src_t'(6'b100000);
      tick(2);
      src <= '0;
      tick(4);
    end
    `CHK(pend_r, 8'h04)
    expect_lvl(2);
    instr(0);
    wait_idle();
    tick(12);
    `CHK(pend_r, 8'h00)
    instr(1);
    soft_irq <= 1'b1;
    swi_data <= 8'hFF;
    tick();
    soft_irq <= 1'b0;
    tick(4);
    do_reset();
    stop_test();
  end
endmodule : tb
`default_nettype wire
